/* hw/ebcs_pkg.sv */
/*
 * Package for the external bus chip select block: register map, field
 * positions, decode constants, modes, commands and carrier structs.
 * Assumes a single 200 MHz core clock and a byte-wide register port.
 */
`default_nettype none

package ebcs_pkg;
    localparam int NUM_CS = 4;
    localparam logic [1:0] FOURTH_CHIP_SELECT = 2'h3;
    // Register port map, byte addresses
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h00;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h01;
    localparam logic [4:0] ADDR_BUS_ENABLE = 5'h02;
    localparam logic [4:0] ADDR_CS_FIRST = 5'h10;
    localparam logic [1:0] OFS_CS_CONTROL_A = 2'h0;
    localparam logic [1:0] OFS_CS_CONTROL_B = 2'h1;
    localparam logic [1:0] OFS_CS_BASE_LO = 2'h2;
    localparam logic [1:0] OFS_CS_BASE_HI = 2'h3;
    // Field positions
    localparam int CTRL_A_SIZE_LSB = 2;
    localparam int CTRL_B_INIT_BIT = 7;
    localparam int CTRL_B_SELF_REFRESH_BIT = 2;
    localparam int BASE_LO_FIELD_LSB = 4;
    // Region size decode
    localparam logic [4:0] SIZE_LAST_COMPARED = 5'h0f;
    localparam logic [4:0] SIZE_WHOLE_SPACE = 5'h10;
    localparam int SIZE_FIRST_LINE = 8;
    localparam int BASE_LOW_LINE = 12;
    // Peripheral 2x clock enable divider (core clock / 2)
    localparam logic [3:0] PER2_DIV_LAST = 4'h1;
    // Interrupt status bits
    localparam int IRQ_INIT_COMPLETE = 0;
    localparam int IRQ_SELF_REFRESH_EXIT = 1;
    localparam int IRQ_UNMAPPED = 2;
    localparam logic [7:0] IRQ_IMPLEMENTED = 8'h07;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        MODE_DISABLED = 2'b00,
        MODE_SRAM = 2'b01,
        MODE_LOW_PIN_COUNT_SRAM = 2'b10,
        MODE_SDRAM = 2'b11
    } ebcs_if_mode_t;

    localparam logic [1:0] ACCESS_NORMAL = 2'b00;
    localparam logic [1:0] ACCESS_LOAD_MODE = 2'b01;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_READ = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_LOAD_MODE = 3'h3,
        CMD_SELF_REFRESH = 3'h4
    } ebcs_sdram_cmd_t;

    typedef struct packed {
        ebcs_if_mode_t mode;
        logic [4:0] region_size_code;
        logic [2:0] ctl_b;
        logic [11:0] region_base;
    } ebcs_cs_cfg_t;

    typedef struct packed {
        logic [23:0] addr;
        logic write;
    } ebcs_acc_req_t;
endpackage

`default_nettype wire

/* hw/ebcs_top.sv */
/*
 * Chip select configuration, address decode and access timing for the
 * external bus interface: four chip selects, wait states, SDRAM self-refresh
 * entry and exit, and an interrupt on block events.
 * Assumes all inputs are on i_core_clk; the SDRAM init sequencer and the
 * global timing registers live outside and feed i_sdram_init_done and
 * i_self_refresh_exit_delay.
 */
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module ebcs_top (
    input wire logic i_core_clk, // Core clock, 200 MHz
    input wire logic i_reset, // Synchronous reset, active high
    input wire logic [4:0] i_reg_addr, // Register byte address
    input wire logic [7:0] i_reg_wdata, // Register write data
    input wire logic i_reg_wr, // Register write strobe
    input wire logic i_reg_rd, // Register read strobe
    output logic [7:0] o_reg_rdata, // Read data, cycle after strobe
    input wire logic i_acc_valid, // Internal access request
    input wire ebcs_pkg::ebcs_acc_req_t i_acc, // Access address and direction
    output logic o_acc_ready, // Access taken when valid and ready
    output logic o_acc_done, // Access finished, one cycle
    output logic [3:0] o_chip_select, // Chip select lines, active high
    output logic o_low_pin_count_sram, // Selected region is low pin count SRAM
    output ebcs_pkg::ebcs_sdram_cmd_t o_sdram_cmd, // SDRAM command, one cycle
    output logic o_sdram_cke, // SDRAM clock enable
    input wire logic i_sdram_init_done, // Init sequence finished pulse
    input wire logic [2:0] i_self_refresh_exit_delay, // Exit delay in 2x cycles
    output logic o_irq // Interrupt, level
);
    import ebcs_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } ebcs_state_t;

    ebcs_cs_cfg_t cfg [NUM_CS];
    ebcs_state_t state;
    logic [3:0] div_cnt;
    logic per2_tick;
    logic bus_enable;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] irq_event;
    logic init_complete;
    logic sr_exiting;
    logic [2:0] sr_exit_cnt;
    logic [2:0] wait_cnt;
    logic [NUM_CS-1:0] hit;
    logic [1:0] hit_idx;
    logic any_hit;
    logic cs_wr;
    logic [1:0] cs_idx;
    logic sdram_live;
    logic sr_enter;
    logic sr_leave;
    logic status_read;
    logic accept;
    logic [7:0] next_rdata;

    // Peripheral 2x clock enable
    always_ff @(posedge i_core_clk) begin
        if (i_reset || div_cnt == PER2_DIV_LAST) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    assign per2_tick = (div_cnt == PER2_DIV_LAST);

    // Region decode
    always_comb begin
        logic [23:0] base_full;
        logic [23:0] cmp_mask;
        base_full = 24'h0;
        cmp_mask = 24'h0;
        for (int n = 0; n < NUM_CS; n++) begin
            base_full = {cfg[n].region_base, 12'h000};
            cmp_mask = 24'hffffff << (SIZE_FIRST_LINE + int'(cfg[n].region_size_code));
            if (cfg[n].mode == MODE_DISABLED) begin
                hit[n] = 1'b0;
            end else if (cfg[n].region_size_code == SIZE_WHOLE_SPACE) begin
                hit[n] = 1'b1;
            end else if (cfg[n].region_size_code > SIZE_LAST_COMPARED) begin
                hit[n] = 1'b0;
            end else begin
                hit[n] = ((i_acc.addr ^ base_full) & cmp_mask) == 24'h0;
            end
        end
    end

    always_comb begin
        hit_idx = 2'h0;
        for (int n = NUM_CS - 1; n >= 0; n--) begin
            if (hit[n]) begin
                hit_idx = 2'(n);
            end
        end
    end
    assign any_hit = |hit;

    assign cs_wr = i_reg_wr && i_reg_addr[4] == ADDR_CS_FIRST[4];
    assign cs_idx = i_reg_addr[3:2];
    assign sdram_live = bus_enable && cfg[FOURTH_CHIP_SELECT].mode == MODE_SDRAM;
    assign sr_enter = cs_wr && cs_idx == FOURTH_CHIP_SELECT && i_reg_addr[1:0] == OFS_CS_CONTROL_B
        && sdram_live && i_reg_wdata[CTRL_B_SELF_REFRESH_BIT]
        && !cfg[FOURTH_CHIP_SELECT].ctl_b[CTRL_B_SELF_REFRESH_BIT];
    assign sr_leave = cs_wr && cs_idx == FOURTH_CHIP_SELECT && i_reg_addr[1:0] == OFS_CS_CONTROL_B
        && !i_reg_wdata[CTRL_B_SELF_REFRESH_BIT]
        && cfg[FOURTH_CHIP_SELECT].ctl_b[CTRL_B_SELF_REFRESH_BIT];
    assign status_read = i_reg_rd && i_reg_addr == ADDR_IRQ_STATUS;

    // Chip select configuration registers
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int n = 0; n < NUM_CS; n++) begin
                cfg[n] <= '0;
            end
        end else if (cs_wr) begin
            unique case (i_reg_addr[1:0])
                OFS_CS_CONTROL_A: begin
                    cfg[cs_idx].region_size_code <= i_reg_wdata[CTRL_A_SIZE_LSB +: 5];
                    if (cs_idx != FOURTH_CHIP_SELECT && i_reg_wdata[1:0] == MODE_SDRAM) begin
                        cfg[cs_idx].mode <= MODE_DISABLED;
                    end else begin
                        cfg[cs_idx].mode <= ebcs_if_mode_t'(i_reg_wdata[1:0]);
                    end
                end
                OFS_CS_CONTROL_B: cfg[cs_idx].ctl_b <= i_reg_wdata[2:0];
                OFS_CS_BASE_LO: cfg[cs_idx].region_base[3:0] <= i_reg_wdata[BASE_LO_FIELD_LSB +: 4];
                OFS_CS_BASE_HI: cfg[cs_idx].region_base[11:4] <= i_reg_wdata;
            endcase
        end
    end

    // Global enable and interrupt mask
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            bus_enable <= 1'b0;
            irq_mask <= RESET_BYTE;
        end else if (i_reg_wr && i_reg_addr == ADDR_BUS_ENABLE) begin
            bus_enable <= i_reg_wdata[0];
        end else if (i_reg_wr && i_reg_addr == ADDR_IRQ_MASK) begin
            irq_mask <= i_reg_wdata & IRQ_IMPLEMENTED;
        end
    end

    // SDRAM initialization complete flag
    always_ff @(posedge i_core_clk) begin
        if (i_reset || !sdram_live) begin
            init_complete <= 1'b0;
        end else if (i_sdram_init_done) begin
            init_complete <= 1'b1;
        end
    end

    // Self-refresh clock enable and exit delay
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_sdram_cke <= 1'b1;
            sr_exiting <= 1'b0;
            sr_exit_cnt <= 3'h0;
        end else if (sr_enter) begin
            o_sdram_cke <= 1'b0;
            sr_exiting <= 1'b0;
        end else if (sr_leave && !o_sdram_cke) begin
            o_sdram_cke <= 1'b1;
            sr_exiting <= 1'b1;
            sr_exit_cnt <= i_self_refresh_exit_delay;
        end else if (sr_exiting && sr_exit_cnt == 3'h0) begin
            sr_exiting <= 1'b0;
        end else if (sr_exiting && per2_tick) begin
            sr_exit_cnt <= sr_exit_cnt - 3'h1;
        end
    end

    // Interrupt status: set wins over the clear on read
    always_comb begin
        irq_event = 8'h00;
        irq_event[IRQ_INIT_COMPLETE] = sdram_live && i_sdram_init_done && !init_complete;
        irq_event[IRQ_SELF_REFRESH_EXIT] = sr_exiting && sr_exit_cnt == 3'h0 && !sr_enter;
        irq_event[IRQ_UNMAPPED] = accept && !any_hit;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            irq_status <= RESET_BYTE;
        end else if (status_read) begin
            irq_status <= irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end
    assign o_irq = |(irq_status & irq_mask);

    // Access sequencing; no new access while self-refresh is active or exiting
    assign o_acc_ready = state == ST_IDLE && o_sdram_cke && !sr_exiting && !sr_enter;
    assign accept = i_acc_valid && o_acc_ready;
    assign o_acc_done = state == ST_DONE;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
            wait_cnt <= 3'h0;
            o_chip_select <= 4'h0;
            o_low_pin_count_sram <= 1'b0;
            o_sdram_cmd <= CMD_NOP;
        end else begin
            o_sdram_cmd <= sr_enter ? CMD_SELF_REFRESH : CMD_NOP;
            unique case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state <= ST_DONE;
                        if (any_hit) begin
                            o_chip_select[hit_idx] <= 1'b1;
                            o_low_pin_count_sram <= cfg[hit_idx].mode == MODE_LOW_PIN_COUNT_SRAM;
                            if (cfg[hit_idx].mode == MODE_SDRAM) begin
                                if (cfg[hit_idx].ctl_b[1:0] == ACCESS_LOAD_MODE) begin
                                    o_sdram_cmd <= CMD_LOAD_MODE;
                                end else if (cfg[hit_idx].ctl_b[1:0] == ACCESS_NORMAL) begin
                                    o_sdram_cmd <= i_acc.write ? CMD_WRITE : CMD_READ;
                                end
                            end else if (cfg[hit_idx].ctl_b != 3'h0) begin
                                wait_cnt <= cfg[hit_idx].ctl_b;
                                state <= ST_WAIT;
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    if (per2_tick) begin
                        wait_cnt <= wait_cnt - 3'h1;
                        if (wait_cnt == 3'h1) begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    o_chip_select <= 4'h0;
                    o_low_pin_count_sram <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Register read data, reserved bits zero
    always_comb begin
        ebcs_cs_cfg_t sel;
        sel = cfg[i_reg_addr[3:2]];
        next_rdata = 8'h00;
        if (i_reg_addr[4] == ADDR_CS_FIRST[4]) begin
            unique case (i_reg_addr[1:0])
                OFS_CS_CONTROL_A: next_rdata = {1'b0, sel.region_size_code, sel.mode};
                OFS_CS_CONTROL_B: begin
                    next_rdata = {5'h00, sel.ctl_b};
                    if (sel.mode == MODE_SDRAM) begin
                        next_rdata[CTRL_B_INIT_BIT] = init_complete;
                    end
                end
                OFS_CS_BASE_LO: next_rdata = {sel.region_base[3:0], 4'h0};
                OFS_CS_BASE_HI: next_rdata = sel.region_base[11:4];
            endcase
        end else if (i_reg_addr == ADDR_IRQ_STATUS) begin
            next_rdata = irq_status;
        end else if (i_reg_addr == ADDR_IRQ_MASK) begin
            next_rdata = irq_mask;
        end else if (i_reg_addr == ADDR_BUS_ENABLE) begin
            next_rdata = {7'h00, bus_enable};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reg_rdata <= RESET_BYTE;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
        end else begin
            o_reg_rdata <= RESET_BYTE;
        end
    end
endmodule // ebcs_top

`default_nettype wire

/* tb/ebcs_top_asserts.sv */
/* Port-level checker for ebcs_top.
   Assumes one core clock and the synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module ebcs_top_chk (
    input wire logic i_core_clk, // Core clock
    input wire logic i_reset, // Reset
    input wire logic i_reg_rd, // Read strobe
    input wire logic [7:0] o_reg_rdata, // Read data
    input wire logic i_acc_valid, // Access request
    input wire logic o_acc_ready, // Access ready
    input wire logic o_acc_done, // Access done
    input wire logic [3:0] o_chip_select, // Chip selects
    input wire logic o_low_pin_count_sram, // Low pin count flag
    input wire ebcs_pkg::ebcs_sdram_cmd_t o_sdram_cmd, // SDRAM command
    input wire logic o_sdram_cke, // Clock enable
    input wire logic [2:0] i_self_refresh_exit_delay // Exit delay
);
    import ebcs_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    sequence s_take;
        i_acc_valid && o_acc_ready;
    endsequence
    sequence s_stall;
        !o_acc_ready [*3];
    endsequence
    a_rdata_quiet: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_cs_onehot: assert property ($onehot0(o_chip_select))
        else $error("more than one chip select");
    a_take_done: assert property (s_take |-> ##[1:20] o_acc_done)
        else $error("access never finished");
    a_take_busy: assert property (s_take |=> !o_acc_ready)
        else $error("ready during access");
    a_done_clears: assert property (o_acc_done |=> o_chip_select == 4'h0)
        else $error("chip select held after done");
    a_cs_cause: assert property ($rose(|o_chip_select) |-> $past(i_acc_valid && o_acc_ready))
        else $error("chip select without access");
    a_lpc_with_cs: assert property (o_low_pin_count_sram |-> |o_chip_select)
        else $error("low pin count flag alone");
    a_cmd_pulse: assert property (o_sdram_cmd != CMD_NOP |=> o_sdram_cmd == CMD_NOP)
        else $error("command longer than one cycle");
    a_data_cmd_cs: assert property (o_sdram_cmd inside {CMD_READ, CMD_WRITE, CMD_LOAD_MODE}
        |-> o_chip_select == 4'h8)
        else $error("SDRAM command off fourth chip select");
    a_sref_cke: assert property (o_sdram_cmd == CMD_SELF_REFRESH |-> !o_sdram_cke)
        else $error("clock enable high in self-refresh");
    a_cke_stall: assert property (!o_sdram_cke |-> !o_acc_ready)
        else $error("ready while clock enable low");
    a_exit_wait: assert property ($rose(o_sdram_cke) && i_self_refresh_exit_delay >= 3'h2 |-> s_stall)
        else $error("exit delay cut short");
    a_exit_ends: assert property ($rose(o_sdram_cke) |-> ##[1:20] o_acc_ready)
        else $error("exit delay never ended");
endmodule // ebcs_top_chk

bind ebcs_top ebcs_top_chk ebcs_top_chk_inst (.i_core_clk, .i_reset, .i_reg_rd, .o_reg_rdata, .i_acc_valid,
    .o_acc_ready, .o_acc_done, .o_chip_select, .o_low_pin_count_sram, .o_sdram_cmd, .o_sdram_cke,
    .i_self_refresh_exit_delay);
`default_nettype wire

/* tb/ebcs_mem_model.sv */
/* SDRAM side model: init sequencer pulse and self-refresh tracking.
   Assumes commands and clock enable come straight from ebcs_top. */
`timescale 1ns/100ps
`default_nettype none
module ebcs_mem_model #(
    parameter int INIT_CYCLES = 8
) (
    input wire logic i_core_clk, // Clock
    input wire logic i_reset, // Reset
    input wire logic i_power_up, // Start of initialization
    input wire ebcs_pkg::ebcs_sdram_cmd_t i_sdram_cmd, // Command
    input wire logic i_sdram_cke, // Clock enable
    output logic o_init_done, // Init finished, one cycle
    output logic [7:0] o_faults // Commands taken while asleep
);
    import ebcs_pkg::*;
    int count;
    logic asleep;
    always_ff @(posedge i_core_clk) begin
        o_init_done <= 1'b0;
        if (i_reset) begin
            count <= 0;
            asleep <= 1'b0;
            o_faults <= 8'h00;
        end else begin
            if (i_power_up) begin
                count <= INIT_CYCLES;
            end else if (count > 0) begin
                count <= count - 1;
                o_init_done <= (count == 1);
            end
            if (i_sdram_cmd == CMD_SELF_REFRESH) asleep <= 1'b1;
            else if (i_sdram_cke) asleep <= 1'b0;
            if (asleep && i_sdram_cmd != CMD_NOP) o_faults <= o_faults + 8'h01;
        end
    end
endmodule // ebcs_mem_model
`default_nettype wire

/* tb/tb_top.sv */
/* Self-checking bench for ebcs_top with the SDRAM side model.
   Assumes a 200 MHz core clock and the register map of the package. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ebcs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, valid = 1'b0, pwr = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, rdata, faults;
    ebcs_acc_req_t acc = '0;
    logic [2:0] delay = 3'h3;
    logic ready, done, low_pin_count_sram, cke, irq, idone, s_cke;
    logic [3:0] cs;
    ebcs_sdram_cmd_t cmd, s_cmd;
    int mismatches = 0, n_tests = 0, cycles = 0;
    always #2.5 clk = ~clk;
    ebcs_top ebcs_top_inst (.i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_acc_valid(valid), .i_acc(acc),
        .o_acc_ready(ready), .o_acc_done(done), .o_chip_select(cs), .o_low_pin_count_sram(low_pin_count_sram),
        .o_sdram_cmd(cmd), .o_sdram_cke(cke), .i_sdram_init_done(idone), .i_self_refresh_exit_delay(delay),
        .o_irq(irq));
    ebcs_mem_model ebcs_mem_model_inst (.i_core_clk(clk), .i_reset(rst), .i_power_up(pwr), .i_sdram_cmd(cmd),
        .i_sdram_cke(cke), .o_init_done(idone), .o_faults(faults));
    task automatic summarize();
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cs(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: chip select %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("wrong value at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask
    function automatic logic hit(input logic [23:0] a, input logic [11:0] b, input logic [4:0] s);
        logic [23:0] m;
        m = 24'hffffff << (8 + s);
        if (s == 5'h10) return 1'b1;
        return s < 5'h10 && ((a ^ {b, 12'h000}) & m) == 24'h0;
    endfunction
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
        @(negedge clk) {s_cmd, s_cke} = {cmd, cke};
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        @(negedge clk) d = rdata;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk_byte(d, exp);
    endtask
    task automatic access(input logic [23:0] a, input logic w, output logic [3:0] c,
        output ebcs_sdram_cmd_t k, output logic l, output int n);
        valid <= 1'b1;
        acc <= '{addr: a, write: w};
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            if (ready) break;
            @(posedge clk);
        end
        @(posedge clk) valid <= 1'b0;
        @(negedge clk) {c, k, l} = {cs, cmd, low_pin_count_sram};
        for (n = 1; n < 40 && !done; n++) @(negedge clk);
        @(posedge clk);
    endtask
    initial begin
        logic [3:0] c;
        ebcs_sdram_cmd_t k;
        logic l;
        int n;
        logic [4:0] sz;
        logic [11:0] base;
        logic [23:0] a;
        n = $urandom(32'h8f52);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 16; i < 32; i++) rdchk(5'(i), 8'h00);
        wr(5'h10, 8'hff);
        rdchk(5'h10, 8'h7c);
        wr(5'h11, 8'hff);
        rdchk(5'h11, 8'h07);
        wr(5'h12, 8'hff);
        rdchk(5'h12, 8'hf0);
        wr(5'h1c, 8'h03);
        rdchk(5'h1c, 8'h03);
        wr(5'h1c, 8'h00);
        wr(5'h05, 8'hff);
        rdchk(5'h05, 8'h00);
        for (int i = 0; i < 30; i++) begin
            sz = 5'($urandom_range(20));
            base = 12'($urandom);
            a = 24'($urandom);
            if ($urandom_range(1) == 1) a[23:8] = {base, 4'h0};
            wr(5'h14, {1'b0, sz, 2'b01});
            wr(5'h16, {base[3:0], 4'h0});
            wr(5'h17, base[11:4]);
            access(a, 1'($urandom), c, k, l, n);
            chk_cs(c, hit(a, base, sz) ? 4'h2 : 4'h0);
        end
        for (int md = 0; md < 3; md++) begin
            wr(5'h14, {1'b0, 5'h10, 2'(md)});
            access(24'($urandom), 1'b0, c, k, l, n);
            chk_cs(c, md == 0 ? 4'h0 : 4'h2);
            chk_byte({7'h0, l}, md == 2 ? 8'h01 : 8'h00);
        end
        wr(5'h14, 8'h41);
        for (int w = 0; w < 8; w++) begin
            wr(5'h15, 8'(w));
            access(24'($urandom), 1'b1, c, k, l, n);
            chk_cnt(n, w == 0 ? 1 : 2 * w, w == 0 ? 1 : 2 * w + 2);
        end
        wr(5'h14, 8'h00);
        wr(5'h1c, 8'h43);
        for (int j = 0; j < 4; j++) begin
            wr(5'h1d, 8'(j / 2));
            access(24'($urandom), 1'(j), c, k, l, n);
            chk_cs(c, 4'h8);
            chk_byte(8'(k), j > 1 ? 8'(CMD_LOAD_MODE) : j == 1 ? 8'(CMD_WRITE) : 8'(CMD_READ));
        end
        rdchk(5'h00, 8'h04);
        wr(5'h01, 8'h07);
        wr(5'h02, 8'h01);
        pwr <= 1'b1;
        @(posedge clk) pwr <= 1'b0;
        repeat (12) @(posedge clk);
        rdchk(5'h1d, 8'h81);
        chk_byte({7'h0, irq}, 8'h01);
        rdchk(5'h00, 8'h01);
        chk_byte({7'h0, irq}, 8'h00);
        wr(5'h02, 8'h00);
        rdchk(5'h1d, 8'h01);
        wr(5'h02, 8'h01);
        wr(5'h01, 8'h00);
        wr(5'h1d, 8'h04);
        chk_byte({s_cke, 4'h0, s_cmd}, {1'b0, 4'h0, CMD_SELF_REFRESH});
        chk_byte({7'h0, ready}, 8'h00);
        wr(5'h1d, 8'h00);
        chk_byte({7'h0, s_cke}, 8'h01);
        @(negedge clk);
        for (n = 0; n < 40 && !ready; n++) @(negedge clk);
        chk_cnt(n, 2 * delay - 2, 2 * delay + 1);
        chk_byte({7'h0, irq}, 8'h00);
        @(posedge clk);
        rdchk(5'h00, 8'h02);
        chk_byte(faults, 8'h00);
        // Second reset in mid-run: configuration must return to zero
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(5'h1c, 8'h00);
        rdchk(5'h1d, 8'h00);
        rdchk(5'h02, 8'h00);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
